/* File: pit_pkg.sv */
// periodic timer package: register map, field layout, reset values, divide ratios, carriers
// assumes a single 100 MHz clock and a plain byte-addressed register port
// Operation
// - prescale select bypasses or divides by 512
// - strap sets prescale default at reset
// - source is reference, or reference/128 fast with synthesizer on
// - selected clock divided by four again
// - modulus field sets countdown start value
// - zero modulus stops counting and requests
// - expiry requests interrupt, reloads, repeats
// - new nonzero modulus loads only at reload, zero halts at once
// - level field sets priority, zero disables
// - timer beats same-level external request
// - counter runs while interrupt is disabled
// - acknowledge drives programmed vector onto bus
// - vector field resets to 0f
// - stop saves mask, gates clocks by select
// - bus, halt, spurious monitors idle in stop
// - watchdog frozen in stop, resumes after
// - stop never clears watchdog, service does
// - timer keeps running during stop
// - higher request or reset ends stop
package pit_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses of aligned words
  localparam logic [7:0] TIMER_MODULUS_REGISTER_ADDR = 8'h00;
  localparam logic [7:0] TIMER_INTERRUPT_CONTROL_REGISTER_ADDR = 8'h04;
  localparam logic [7:0] WATCHDOG_SERVICE_REGISTER_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;
  localparam logic [7:0] WATCHDOG_COUNT_ADDR = 8'h10;

  // field positions
  localparam int MODULUS_LSB = 0;
  localparam int PRESCALE_BIT = 8;
  localparam int VECTOR_LSB = 0;
  localparam int LEVEL_LSB = 8;
  localparam int STAT_PENDING_BIT = 8;
  localparam int STAT_STOP_BIT = 9;
  localparam int STAT_PLL_BIT = 10;

  // reset values
  localparam logic [7:0] MODULUS_RESET = 8'h00;
  localparam logic [2:0] LEVEL_RESET = 3'h0;
  localparam logic [7:0] VECTOR_RESET = 8'h0f;

  // watchdog service sequence
  localparam logic [7:0] SERVICE_FIRST = 8'h55;
  localparam logic [7:0] SERVICE_SECOND = 8'haa;

  // divide ratios
  localparam int unsigned FAST_REF_DIV = 128;
  localparam int unsigned PRESCALE_DIV = 512;
  localparam int unsigned FINAL_DIV = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers and states
  typedef struct packed {
    logic valid;
    logic [2:0] level;
  } pit_ack_t;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
  } pit_vec_t;

  typedef enum logic {PWR_RUN = 1'b0, PWR_STOP = 1'b1} pit_pwr_t;
  typedef enum logic {SVC_IDLE = 1'b0, SVC_ARMED = 1'b1} pit_svc_t;

endpackage

/* File: pit_divider.sv */
// enable-pulse divider: one output pulse per RATIO input pulses
// assumes tickIn is a one-cycle enable synchronous to clock
`timescale 1ns/10ps
`default_nettype none
module pit_divider #(
  parameter int unsigned RATIO = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // enable pulses
  input wire logic tickIn,
  output logic tickOut
);

  localparam int W = $clog2(RATIO);
  localparam logic [W-1:0] LAST = W'(RATIO - 1);

  logic [W-1:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////////
  // count input pulses, free running so the ratio is exact across selections
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      tickOut <= 1'b0;
    end else begin
      tickOut <= 1'b0;
      if (tickIn) begin
        if (cnt_q == LAST) begin
          cnt_q <= '0;
          tickOut <= 1'b1;
        end else begin
          cnt_q <= cnt_q + W'(1);
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: pit_timer.sv */
// periodic interrupt timer with stop control and watchdog count freeze
// assumes all inputs synchronous to clock; refTick is a one-cycle reference pulse
`timescale 1ns/10ps
`default_nettype none
module pit_timer (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // straps and reference
  input wire logic clockModeStrap,
  input wire logic fastReference,
  input wire logic refTick,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  // interrupt arbitration
  input wire logic [2:0] extIrqLevel,
  input wire pit_pkg::pit_ack_t ackIn,
  output logic [2:0] reqLevel,
  output logic timerWins,
  output logic extAckPass,
  output pit_pkg::pit_vec_t vectorBus,
  // low-power stop
  input wire logic lowPowerStopInstruction,
  input wire logic [2:0] cpuMask,
  input wire logic stopClockSelect,
  output logic stopMode,
  output logic sysClockGate,
  output logic monitorsEnable
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // strict priority comparison used for arbitration and wake-up
  function automatic logic levelAbove(input logic [2:0] a, input logic [2:0] b);
    levelAbove = (a > b);
  endfunction

  // address match on a strobe
  function automatic logic hit(input logic strobe, input logic [7:0] addr,
                               input logic [7:0] target);
    hit = strobe && (addr == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic strapDone_q;
  logic pllOn_q;
  logic timerPrescaleSelect_q;
  logic [7:0] timerModulusField_q;
  logic [2:0] timerRequestLevel_q;
  logic [7:0] timerVectorField_q;
  logic [7:0] count_q;
  logic pending_q;
  logic [2:0] savedMask_q;
  logic [15:0] watchdogCount_q;
  pit_pkg::pit_pwr_t pwr_q;
  pit_pkg::pit_svc_t svc_q;

  logic fastTick;
  logic srcTick;
  logic preTick;
  logic slowTick;
  logic finalTick;
  logic expire;
  logic ackTimer;
  logic [2:0] timerLevel;
  logic [2:0] levelNow;

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture: sampled by a clocked process after reset release, never async

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strapDone_q <= 1'b0;
      pllOn_q <= 1'b0;
    end else if (!strapDone_q) begin
      strapDone_q <= 1'b1;
      pllOn_q <= clockModeStrap; // strap high runs the synthesizer
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock chain: optional /128, optional /512, then /4

  pit_divider #(.RATIO(pit_pkg::FAST_REF_DIV)) fastDiv (
    .clock(clock),
    .rstn(rstn),
    .tickIn(refTick),
    .tickOut(fastTick)
  );

  // fast reference with synthesizer on is divided, otherwise reference used
  assign srcTick = (pllOn_q && fastReference) ? fastTick : refTick;

  pit_divider #(.RATIO(pit_pkg::PRESCALE_DIV)) preDiv (
    .clock(clock),
    .rstn(rstn),
    .tickIn(srcTick),
    .tickOut(preTick)
  );

  // prescale select picks the /512 path or bypasses it
  assign slowTick = timerPrescaleSelect_q ? preTick : srcTick;

  // whichever is selected is divided by four before the counter
  pit_divider #(.RATIO(pit_pkg::FINAL_DIV)) finalDiv (
    .clock(clock),
    .rstn(rstn),
    .tickIn(slowTick),
    .tickOut(finalTick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // timer modulus register: modulus and prescale select

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timerModulusField_q <= pit_pkg::MODULUS_RESET;
      timerPrescaleSelect_q <= 1'b0;
    end else if (!strapDone_q) begin
      // strap low means external clock, default to /512
      timerPrescaleSelect_q <= !clockModeStrap;
    end else if (hit(regWrite, regAddr, pit_pkg::TIMER_MODULUS_REGISTER_ADDR)) begin
      timerModulusField_q <= regWrData[pit_pkg::MODULUS_LSB +: 8];
      timerPrescaleSelect_q <= regWrData[pit_pkg::PRESCALE_BIT]; // software may override
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt control register: level and vector

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timerRequestLevel_q <= pit_pkg::LEVEL_RESET;
      timerVectorField_q <= pit_pkg::VECTOR_RESET; // uninitialized vector
    end else if (hit(regWrite, regAddr, pit_pkg::TIMER_INTERRUPT_CONTROL_REGISTER_ADDR)) begin
      timerRequestLevel_q <= regWrData[pit_pkg::LEVEL_LSB +: 3];
      timerVectorField_q <= regWrData[pit_pkg::VECTOR_LSB +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // modulus down-counter
  // runs regardless of the level field and of stop mode; a written nonzero modulus
  // is only picked up at the reload, so only a written zero modulus cuts a long count short

  // expiry is the tick at a count of one with a nonzero modulus, which reloads instead of reaching zero
  assign expire = finalTick && (timerModulusField_q != 8'h00) && (count_q == 8'h01);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_q <= 8'h00;
    end else if (finalTick) begin
      if (timerModulusField_q == 8'h00) begin
        count_q <= 8'h00; // zero modulus halts the counter
      end else if (count_q <= 8'h01) begin
        count_q <= timerModulusField_q; // reload and repeat
      end else begin
        count_q <= count_q - 8'h01; // keeps counting in stop, level ignored
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request pending flag; a new expiry wins over an acknowledge in the same cycle

  assign timerLevel = pending_q ? timerRequestLevel_q : 3'h0;
  assign ackTimer = ackIn.valid && pending_q && (ackIn.level == timerRequestLevel_q);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pending_q <= 1'b0;
    end else if (expire && (timerRequestLevel_q != 3'h0)) begin
      pending_q <= 1'b1; // level zero never raises a request
    end else if (ackTimer || (timerRequestLevel_q == 3'h0)) begin
      pending_q <= 1'b0; // cleared by its own acknowledge or by a level of zero
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // arbitration toward the core; ties go to the timer

  // highest active level seen by the core and the stop wake logic
  assign levelNow = levelAbove(extIrqLevel, timerLevel) ? extIrqLevel : timerLevel;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reqLevel <= 3'h0;
      timerWins <= 1'b0;
    end else begin
      reqLevel <= levelNow;
      timerWins <= (timerLevel != 3'h0) && !levelAbove(extIrqLevel, timerLevel);
    end
  end

  // acknowledge answer: timer vector first, else pass to the external source
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      vectorBus <= '0;
      extAckPass <= 1'b0;
    end else begin
      vectorBus.valid <= ackTimer;
      vectorBus.vector <= ackTimer ? timerVectorField_q : 8'h00;
      extAckPass <= ackIn.valid && !ackTimer && (ackIn.level == extIrqLevel);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // low-power stop control

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pwr_q <= pit_pkg::PWR_RUN; // reset also ends stop
      savedMask_q <= 3'h0;
    end else begin
      unique case (pwr_q)
        pit_pkg::PWR_RUN: begin
          if (lowPowerStopInstruction) begin
            pwr_q <= pit_pkg::PWR_STOP;
            savedMask_q <= cpuMask; // mask kept in clock control
          end
        end
        pit_pkg::PWR_STOP: begin
          if (levelAbove(levelNow, savedMask_q)) begin
            pwr_q <= pit_pkg::PWR_RUN; // request above saved mask wakes
          end
        end
      endcase
    end
  end

  // registered stop outputs; monitors idle while stopped, clocks gated in stop when stopClockSelect is low
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stopMode <= 1'b0;
      sysClockGate <= 1'b0;
      monitorsEnable <= 1'b1;
    end else begin
      stopMode <= (pwr_q == pit_pkg::PWR_STOP);
      sysClockGate <= (pwr_q == pit_pkg::PWR_STOP) && !stopClockSelect;
      monitorsEnable <= (pwr_q == pit_pkg::PWR_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog count: frozen in stop, restarted only by a full service sequence
  // the timeout compare lives elsewhere; only the count is kept here

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      svc_q <= pit_pkg::SVC_IDLE;
    end else if (hit(regWrite, regAddr, pit_pkg::WATCHDOG_SERVICE_REGISTER_ADDR)) begin
      unique case (svc_q)
        pit_pkg::SVC_IDLE: begin
          if (regWrData[7:0] == pit_pkg::SERVICE_FIRST) begin
            svc_q <= pit_pkg::SVC_ARMED;
          end
        end
        pit_pkg::SVC_ARMED: begin
          // a repeated first byte keeps the sequence armed
          if (regWrData[7:0] != pit_pkg::SERVICE_FIRST) begin
            svc_q <= pit_pkg::SVC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      watchdogCount_q <= 16'h0000;
    end else if (hit(regWrite, regAddr, pit_pkg::WATCHDOG_SERVICE_REGISTER_ADDR)
                 && (svc_q == pit_pkg::SVC_ARMED)
                 && (regWrData[7:0] == pit_pkg::SERVICE_SECOND)) begin
      watchdogCount_q <= 16'h0000; // only service restarts the count
    end else if (pwr_q == pit_pkg::PWR_RUN) begin
      watchdogCount_q <= watchdogCount_q + 16'h0001; // held while stopped
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port: data in the cycle after the strobe, unmapped reads return zero

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      regRdData <= 16'h0000;
    end else if (regRead) begin
      unique case (regAddr)
        pit_pkg::TIMER_MODULUS_REGISTER_ADDR: begin
          regRdData <= {7'h00, timerPrescaleSelect_q, timerModulusField_q};
        end
        pit_pkg::TIMER_INTERRUPT_CONTROL_REGISTER_ADDR: begin
          regRdData <= {5'h00, timerRequestLevel_q, timerVectorField_q};
        end
        pit_pkg::STATUS_ADDR: begin
          regRdData <= {5'h00, pllOn_q, (pwr_q == pit_pkg::PWR_STOP), pending_q, count_q};
        end
        pit_pkg::WATCHDOG_COUNT_ADDR: begin
          regRdData <= watchdogCount_q;
        end
        default: begin
          regRdData <= 16'h0000; // service register is write only
        end
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

/* File: pit_timer_properties.sv */
// port assertions for the periodic timer block
// assumes one clock domain and that cpuMask holds steady while stopped
`timescale 1ns/10ps
`default_nettype none
module pit_timer_properties (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // arbitration
  input wire logic [2:0] extIrqLevel,
  input wire pit_pkg::pit_ack_t ackIn,
  input wire logic [2:0] reqLevel,
  input wire logic timerWins,
  input wire logic extAckPass,
  input wire pit_pkg::pit_vec_t vectorBus,
  // low-power stop
  input wire logic lowPowerStopInstruction,
  input wire logic [2:0] cpuMask,
  input wire logic stopMode,
  input wire logic sysClockGate,
  input wire logic monitorsEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////////////
  // acknowledge and vector
  timer_vector_a: assert property (ackIn.valid && timerWins && ackIn.level == reqLevel |=> vectorBus.valid)
    else $error("no vector after timer acknowledge");
  vector_cause_a: assert property (vectorBus.valid |-> $past(ackIn.valid) ##1 !vectorBus.valid)
    else $error("vector without acknowledge or too long");
  tie_timer_a: assert property (timerWins |-> reqLevel != 3'h0 && reqLevel >= $past(extIrqLevel))
    else $error("timer precedence with wrong level");
  req_max_a: assert property ($past(rstn) |-> reqLevel >= $past(extIrqLevel))
    else $error("request level below external level");
  ext_pass_a: assert property (ackIn.valid && extIrqLevel != 3'h0 && ackIn.level == extIrqLevel
    |=> extAckPass || vectorBus.valid)
    else $error("acknowledge taken by nobody");
  ext_excl_a: assert property (extAckPass |-> !vectorBus.valid)
    else $error("acknowledge passed and taken at once");
  //////////////////////////////////////////////////////////////////////////////
  // stop entry and exit
  stop_enter_a: assert property (lowPowerStopInstruction && !stopMode && reqLevel <= cpuMask
    && extIrqLevel <= cpuMask |-> ##2 stopMode && !monitorsEnable)
    else $error("stop not entered");
  monitors_a: assert property (monitorsEnable != stopMode)
    else $error("monitors active in stop");
  gate_a: assert property (sysClockGate |-> stopMode)
    else $error("clocks gated outside stop");
  stop_exit_a: assert property (stopMode && extIrqLevel > cpuMask |-> ##[1:2] !stopMode)
    else $error("stop not left on higher request");
endmodule
bind pit_timer pit_timer_properties i_pit_timer_properties (.clock(clock), .rstn(rstn),
  .extIrqLevel(extIrqLevel), .ackIn(ackIn), .reqLevel(reqLevel), .timerWins(timerWins),
  .extAckPass(extAckPass), .vectorBus(vectorBus),
  .lowPowerStopInstruction(lowPowerStopInstruction), .cpuMask(cpuMask),
  .stopMode(stopMode), .sysClockGate(sysClockGate), .monitorsEnable(monitorsEnable));
`default_nettype wire

/* File: pit_core_model.sv */
// core interrupt model: acknowledges the request level after a delay
// assumes reqLevel is the timer's registered arbitration result
`timescale 1ns/10ps
`default_nettype none
module pit_core_model #(
  parameter int unsigned DELAY = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // from the timer and the core state
  input wire logic [2:0] reqLevel,
  input wire logic stopMode,
  input wire logic [2:0] cpuMask,
  // acknowledge
  output pit_pkg::pit_ack_t ackIn,
  output logic [2:0] lastAckLevel
);
  int unsigned waitQ;
  //////////////////////////////////////////////////////////////////////////////
  // ack only above the mask and never while stopped; wait restarts so a
  // stale level seen just after an ack is not acknowledged twice
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ackIn <= '0;
      waitQ <= 0;
      lastAckLevel <= 3'h0;
    end else begin
      ackIn <= '0;
      if (reqLevel > cpuMask && !stopMode) begin
        waitQ <= waitQ + 1;
        if (waitQ >= DELAY) begin
          ackIn <= {1'b1, reqLevel};
          lastAckLevel <= reqLevel;
          waitQ <= 0;
        end
      end else begin
        waitQ <= 0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench: register tasks, core model, event counters
// assumes strap high and refTick every cycle, so one count per 4 clocks
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic lowPowerStopInstruction = 1'b0;
  logic [2:0] extIrqLevel = 3'h0;
  logic [2:0] cpuMask = 3'h0;
  logic fastRef = 1'b0;
  logic [15:0] regRdData, rd, rd2, wd;
  logic [2:0] reqLevel, lastAckLevel;
  logic timerWins, extAckPass, stopMode, sysClockGate, monitorsEnable;
  pit_pkg::pit_ack_t ackIn;
  pit_pkg::pit_vec_t vectorBus;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  int passCount = 0;
  int vecCount = 0;
  time t1, t2;
  //////////////////////////////////////////////////////////////////////////////
  pit_timer i_pit_timer (.clock(clock), .rstn(rstn), .clockModeStrap(1'b1),
    .fastReference(fastRef), .refTick(1'b1), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .extIrqLevel(extIrqLevel), .ackIn(ackIn), .reqLevel(reqLevel), .timerWins(timerWins),
    .extAckPass(extAckPass), .vectorBus(vectorBus),
    .lowPowerStopInstruction(lowPowerStopInstruction), .cpuMask(cpuMask),
    .stopClockSelect(1'b0), .stopMode(stopMode), .sysClockGate(sysClockGate),
    .monitorsEnable(monitorsEnable));
  pit_core_model #(.DELAY(2)) i_pit_core_model (.clock(clock), .rstn(rstn),
    .reqLevel(reqLevel), .stopMode(stopMode), .cpuMask(cpuMask), .ackIn(ackIn),
    .lastAckLevel(lastAckLevel));
  //////////////////////////////////////////////////////////////////////////////
  always #5 clock = ~clock;
  // run-length ceiling and event counters
  always @(posedge clock) begin
    cycles++;
    if (extAckPass === 1'b1) passCount++;
    if (vectorBus.valid === 1'b1) vecCount++;
    if (cycles == 30000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes; data stands only in the cycle after a read
  task automatic regWr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic regRd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  // bounded wait for a vector pulse, time of zero means none came
  task automatic waitVec(output time t);
    t = 0;
    for (int n = 0; n < 3000 && t == 0; n++) begin
      @(posedge clock);
      #1 if (vectorBus.valid === 1'b1) t = $time;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    regRd(8'h00, rd); check(rd, 16'h0000);
    regRd(8'h04, rd); check(rd, 16'h000f);
    regRd(8'h0c, rd); check(rd, 16'h0400);
    regRd(8'h14, rd); check(rd, 16'h0000);
    // period, vector and reload of a new modulus at expiry only
    regWr(8'h04, 16'h0340);
    regWr(8'h00, 16'h0005);
    waitVec(t1);
    waitVec(t2); check(16'((t2 - t1) / 10), 16'h0014);
    check(16'(vectorBus.vector), 16'h0040);
    check(16'(lastAckLevel), 16'h0003);
    regWr(8'h00, 16'h0009);
    waitVec(t1); check(16'((t1 - t2) / 10), 16'h0014);
    waitVec(t2); check(16'((t2 - t1) / 10), 16'h0024);
    // modulus 1 with the prescaler bypassed
    regWr(8'h00, 16'h0001);
    waitVec(t1);
    waitVec(t1);
    // fast reference with the synthesizer on adds a divide by 128
    @(posedge clock);
    fastRef <= 1'b1;
    repeat (20) @(posedge clock);
    waitVec(t1);
    waitVec(t2); check(16'((t2 - t1) / 10), 16'h0200);
    @(posedge clock);
    fastRef <= 1'b0;
    regWr(8'h00, 16'h0101);
    regRd(8'h00, rd); check(rd, 16'h0101);
    // requests raised before the switch must drain before timing starts
    repeat (20) @(posedge clock);
    waitVec(t1);
    waitVec(t2); check(16'((t2 - t1) / 10), 16'h0800);
    regWr(8'h00, 16'h0002);
    waitVec(t1);
    // every nonzero level code is acknowledged at its own level
    for (int l = 1; l < 8; l++) begin
      regWr(8'h04, {5'h00, 3'(l), 8'h40});
      waitVec(t1); check(16'(lastAckLevel), 16'(l));
    end
    // level zero: counter still runs, nothing pends
    regWr(8'h04, 16'h0040);
    regRd(8'h0c, rd);
    repeat (2) @(posedge clock);
    regRd(8'h0c, rd2); check(16'(rd[7:0] !== rd2[7:0]), 16'h0001);
    check(16'(rd[8] | rd2[8]), 16'h0000);
    // modulus zero stops requests
    regWr(8'h00, 16'h0000); // zero modulus halts the timer even with level 3 set
    regWr(8'h04, 16'h0340);
    repeat (20) @(posedge clock);
    rd2 = 16'(vecCount);
    repeat (50) @(posedge clock);
    check(16'(vecCount) - rd2, 16'h0000);
    // tie at level 3: timer first, then the external request passes
    regWr(8'h00, 16'h0002);
    cpuMask <= 3'h7;
    extIrqLevel <= 3'h3;
    repeat (12) @(posedge clock);
    cpuMask <= 3'h0;
    rd2 = 16'(passCount);
    waitVec(t1); check(16'(passCount) - rd2, 16'h0000);
    repeat (12) @(posedge clock);
    check(16'(16'(passCount) > rd2), 16'h0001);
    @(posedge clock);
    extIrqLevel <= 3'h0;
    cpuMask <= 3'h5;
    // stop: watchdog frozen, timer runs, higher external request wakes
    repeat (12) @(posedge clock);
    lowPowerStopInstruction <= 1'b1;
    @(posedge clock);
    lowPowerStopInstruction <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check(16'({stopMode, monitorsEnable, sysClockGate}), 16'h0005);
    regRd(8'h10, wd);
    repeat (20) @(posedge clock);
    regRd(8'h10, rd); check(rd, wd);
    regRd(8'h0c, rd);
    repeat (2) @(posedge clock);
    regRd(8'h0c, rd2); check(16'(rd[7:0] !== rd2[7:0]), 16'h0001);
    @(posedge clock);
    extIrqLevel <= 3'h6;
    repeat (3) @(posedge clock);
    #1 check(16'(stopMode), 16'h0000);
    @(posedge clock);
    extIrqLevel <= 3'h0;
    regRd(8'h10, rd); check(16'(rd >= wd), 16'h0001);
    regWr(8'h08, 16'h0055);
    regWr(8'h08, 16'h00aa);
    regRd(8'h10, rd); check(16'(rd <= 16'h0003), 16'h0001);
    // second stop left by a timer request raised above the saved mask
    @(posedge clock);
    lowPowerStopInstruction <= 1'b1;
    @(posedge clock);
    lowPowerStopInstruction <= 1'b0;
    repeat (3) @(posedge clock);
    regWr(8'h04, 16'h0640);
    repeat (14) @(posedge clock);
    #1 check(16'(stopMode), 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
